// >>> rtl/acr_pkg.sv
// Function
// - offset select 0: calibrate toward mid-code
// - offset select 1: match spare converter output
// - offset averaging depth bits 6:4, reset 6
// - linearity averaging depth bits 2:0, reset 1
// - halted flag sets when background stops
// - halted flag clears when calibration resumes
// - background off: foreground end sets halted flag
// - foreground-complete flag sets on done or skip
// - status pin source: fg, halted, alarm, low
// - source select 0: software bit, pin ignored
// - source select 1: pin, software bit ignored
// - software trigger bit resets high, replaces pin
// - background enable is bit 1, default off
// - trigger low wakes, high keeps converter asleep
//
// Purpose: constants, field layout and carriers of the calibration register group
// Assumes: 8-bit configuration port, registers at their printed offsets
// Notes:   reserved bits are stored as written
package acr_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ACR_OFS_CFG0 = 8'h62; // calibration config 0
   localparam logic [7:0] ACR_OFS_OREF = 8'h65; // offset_reference_config
   localparam logic [7:0] ACR_OFS_AVG  = 8'h68; // calibration_averaging
   localparam logic [7:0] ACR_OFS_STAT = 8'h6a; // calibration_status
   localparam logic [7:0] ACR_OFS_PIN  = 8'h6b; // calibration_pin_config
   localparam logic [7:0] ACR_OFS_SOFT = 8'h6c; // calibration_software_trigger
   localparam logic [7:0] ACR_OFS_LP   = 8'h6e; // low-power calibration config

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ACR_RST_CFG0 = 8'h01;
   localparam logic [7:0] ACR_RST_OREF = 8'h01;
   localparam logic [7:0] ACR_RST_AVG  = 8'h61;
   localparam logic [7:0] ACR_RST_PIN  = 8'h00;
   localparam logic [7:0] ACR_RST_SOFT = 8'h01;
   localparam logic [7:0] ACR_RST_LP   = 8'h88;
   localparam logic [7:0] ACR_ZERO     = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ACR_BG_EN_BIT    = 1; // background_cal_enable in cfg0
   localparam int ACR_OREF_BIT     = 2; // offset_reference_select
   localparam int ACR_OFFSET_AVERAGE_DEPTH_LSB   = 4; // offset_average_depth
   localparam int ACR_LIN_AVG_LSB  = 0; // linearity_average_depth
   localparam int ACR_AVG_W        = 3; // width of both depth fields
   localparam int ACR_PIN_SEL_LSB  = 1; // status pin source
   localparam int ACR_TRIG_SRC_BIT = 0; // trigger_source_select
   localparam int ACR_SOFT_BIT     = 0; // software_trigger_bit
   localparam int ACR_LP_EN_BIT    = 0; // low-power enable
   localparam int ACR_LOWPOWER_TRIGGER_MODE_BIT  = 1; // lowpower_trigger_mode

   // status pin source codes
   typedef enum logic [1:0] {
      ACR_PIN_FG   = 2'b00,
      ACR_PIN_STOP = 2'b01,
      ACR_PIN_ALRM = 2'b10,
      ACR_PIN_LOW  = 2'b11
   } acr_pin_src_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // one-cycle events and levels from the calibration engine
   typedef struct packed {
      logic       foreground_complete_flag;     // foreground finished or skipped
      logic       bg_stopped;  // background stopped at requested phase
      logic       cal_resumed; // calibration operating again
      logic       cal_restart; // calibration held in reset
      logic       alarm;       // alarm level
      logic [2:0] status_code; // engine status code
   } acr_cal_evt_t;

   // settings handed to the calibration engine
   typedef struct packed {
      logic                 offset_reference_select;
      logic                 background_cal_enable;
      logic [ACR_AVG_W-1:0] offset_average_depth;
      logic [ACR_AVG_W-1:0] linearity_average_depth;
      logic                 lowpower_enable;
      logic                 lowpower_trigger_mode;
   } acr_cal_ctrl_t;

   // sticky flag update, a set beats a clear in the same cycle
   function automatic logic acr_flag_next(input logic cur,
                                          input logic set,
                                          input logic clr);
      return set ? 1'b1 : (clr ? 1'b0 : cur);
   endfunction

endpackage

// >>> rtl/acr_trig_sel.sv
// Purpose: calibration trigger source selection
// Assumes: trigger pin is asynchronous to clk
// Notes:   output is a registered level
`timescale 1ns/1ps
`default_nettype none
module acr_trig_sel
   import acr_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic cal_trigger_pin,
   input  wire logic trigger_source_select,
   input  wire logic software_trigger_bit,
   output var  logic cal_trigger
);

   logic sync1_r;     // first synchroniser stage
   logic sync2_r;     // second synchroniser stage
   logic trig_r;      // selected trigger level
   logic trig_nxt;    // next selected level

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   // stages reset high like the idle pin, so no false low trigger follows reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= cal_trigger_pin;
         sync2_r <= sync1_r;
      end
   end

   // pin only when selected, software bit otherwise
   assign trig_nxt = trigger_source_select ? sync2_r
                                           : software_trigger_bit;

   // trigger level, high out of reset like the software bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_r <= 1'b1;
      end else begin
         trig_r <= trig_nxt;
      end
   end

   assign cal_trigger = trig_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   trig_sw_a : assert property (@(posedge clk) disable iff (!reset_n)
      !trigger_source_select |=> cal_trigger == $past(software_trigger_bit))
      else $error("software trigger not followed");
   trig_hw_a : assert property (@(posedge clk) disable iff (!reset_n)
      trigger_source_select |=> cal_trigger == $past(sync2_r))
      else $error("pin trigger not followed");

endmodule // acr_trig_sel
`default_nettype wire

// >>> rtl/acr_cal_regs.sv
// Purpose: calibration control and status registers with status pin and trigger select
// Assumes: engine events are one-cycle pulses on clk; reads answer one cycle later
// Notes:   unmapped reads return zero, writes to status or unmapped offsets are dropped
`timescale 1ns/1ps
`default_nettype none
module acr_cal_regs
   import acr_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_we,
   input  wire logic          reg_re,
   output var  logic [7:0]    reg_rdata,
   input  wire acr_cal_evt_t  cal_evt,
   input  wire logic          cal_trigger_pin,
   output var  acr_cal_ctrl_t cal_ctrl,
   output var  logic          cal_trigger,
   output var  logic          cal_status_pin,
   output var  logic          lp_wake_request
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] cfg0_r;     // calibration config 0
   logic [7:0] oref_r;     // offset_reference_config
   logic [7:0] avg_r;      // calibration_averaging
   logic [7:0] pin_r;      // calibration_pin_config
   logic [7:0] soft_r;     // calibration_software_trigger
   logic [7:0] lp_r;       // low-power config
   logic       fg_flag_r;  // foreground_complete_flag
   logic       stop_flag_r; // background halted flag
   logic [2:0] code_r;     // status code copy
   logic       alarm_r;    // alarm copy
   logic [7:0] rdata_r;    // read answer
   logic       stat_pin_r; // status pin level
   logic       wake_r;     // wake request level

   logic       fg_flag_nxt;   // next foreground flag
   logic       stop_flag_nxt; // next halted flag
   logic       stop_set;      // halted flag set term
   logic       stat_pin_nxt;  // next status pin
   logic       wake_nxt;      // next wake request
   logic [7:0] rdata_nxt;     // selected read data
   logic [7:0] stat_word;     // status register image
   logic       bg_en;         // background calibration enabled
   logic       trig_lvl;      // selected trigger level
   acr_pin_src_t pin_sel;     // status pin source

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic wr_cfg0; // write cfg0
   logic wr_oref; // write offset reference
   logic wr_avg;  // write averaging
   logic wr_pin;  // write pin config
   logic wr_soft; // write software trigger
   logic wr_lp;   // write low-power config

   assign wr_cfg0 = reg_we && (reg_addr == ACR_OFS_CFG0);
   assign wr_oref = reg_we && (reg_addr == ACR_OFS_OREF);
   assign wr_avg  = reg_we && (reg_addr == ACR_OFS_AVG);
   assign wr_pin  = reg_we && (reg_addr == ACR_OFS_PIN);
   assign wr_soft = reg_we && (reg_addr == ACR_OFS_SOFT);
   assign wr_lp   = reg_we && (reg_addr == ACR_OFS_LP);

   // writable registers, reserved bits kept as written
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg0_r <= ACR_RST_CFG0;
         oref_r <= ACR_RST_OREF;
         avg_r  <= ACR_RST_AVG;
         pin_r  <= ACR_RST_PIN;
         soft_r <= ACR_RST_SOFT;
         lp_r   <= ACR_RST_LP;
      end else begin
         if (wr_cfg0) cfg0_r <= reg_wdata;
         if (wr_oref) oref_r <= reg_wdata;
         if (wr_avg)  avg_r  <= reg_wdata;
         if (wr_pin)  pin_r  <= reg_wdata;
         if (wr_soft) soft_r <= reg_wdata;
         if (wr_lp)   lp_r   <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // settings toward the engine
   // ----------------------------------------------------------------
   assign bg_en = cfg0_r[ACR_BG_EN_BIT];
   // 0 steers offsets to mid-code, 1 to the spare converter
   assign cal_ctrl.offset_reference_select = oref_r[ACR_OREF_BIT];
   assign cal_ctrl.background_cal_enable   = bg_en;
   assign cal_ctrl.offset_average_depth    = avg_r[ACR_OFFSET_AVERAGE_DEPTH_LSB +: ACR_AVG_W];
   assign cal_ctrl.linearity_average_depth = avg_r[ACR_LIN_AVG_LSB +: ACR_AVG_W];
   assign cal_ctrl.lowpower_enable         = lp_r[ACR_LP_EN_BIT];
   assign cal_ctrl.lowpower_trigger_mode   = lp_r[ACR_LOWPOWER_TRIGGER_MODE_BIT];

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // halted on a stop, or on foreground end with background off
   assign stop_set      = cal_evt.bg_stopped
                        || (cal_evt.foreground_complete_flag && !bg_en);
   assign stop_flag_nxt = acr_flag_next(stop_flag_r, stop_set,
                                        cal_evt.cal_resumed);
   // done or skipped both report as complete
   assign fg_flag_nxt   = acr_flag_next(fg_flag_r, cal_evt.foreground_complete_flag,
                                        cal_evt.cal_restart);

   // flags change only by engine events, never by the port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fg_flag_r   <= 1'b0;
         stop_flag_r <= 1'b0;
         code_r      <= 3'h0;
         alarm_r     <= 1'b0;
      end else begin
         fg_flag_r   <= fg_flag_nxt;
         stop_flag_r <= stop_flag_nxt;
         code_r      <= cal_evt.status_code;
         alarm_r     <= cal_evt.alarm;
      end
   end

   assign stat_word = {3'h0, code_r, stop_flag_r, fg_flag_r};

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // plain mux, no state is touched by a read
   assign rdata_nxt = (reg_addr == ACR_OFS_CFG0) ? cfg0_r :
                      (reg_addr == ACR_OFS_OREF) ? oref_r :
                      (reg_addr == ACR_OFS_AVG)  ? avg_r  :
                      (reg_addr == ACR_OFS_STAT) ? stat_word :
                      (reg_addr == ACR_OFS_PIN)  ? pin_r  :
                      (reg_addr == ACR_OFS_SOFT) ? soft_r :
                      (reg_addr == ACR_OFS_LP)   ? lp_r   : ACR_ZERO;

   // read answer held until the next read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= ACR_ZERO;
      end else if (reg_re) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------
   // status pin
   // ----------------------------------------------------------------
   assign pin_sel = acr_pin_src_t'(pin_r[ACR_PIN_SEL_LSB +: 2]);

   // source mux for the status pin
   always_comb begin
      case (pin_sel)
         ACR_PIN_FG:   stat_pin_nxt = fg_flag_r;
         ACR_PIN_STOP: stat_pin_nxt = stop_flag_r;
         ACR_PIN_ALRM: stat_pin_nxt = alarm_r;
         ACR_PIN_LOW:  stat_pin_nxt = 1'b0;
         default:      stat_pin_nxt = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // trigger select and wake request
   // ----------------------------------------------------------------
   acr_trig_sel u_trig (
      .clk                   (clk),
      .reset_n               (reset_n),
      .cal_trigger_pin       (cal_trigger_pin),
      .trigger_source_select (pin_r[ACR_TRIG_SRC_BIT]),
      .software_trigger_bit  (soft_r[ACR_SOFT_BIT]),
      .cal_trigger           (trig_lvl)
   );

   // in trigger mode a low level wakes, a high level keeps asleep
   assign wake_nxt = cal_ctrl.lowpower_enable && cal_ctrl.lowpower_trigger_mode
                     && !trig_lvl;

   // registered pin and wake outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_pin_r <= 1'b0;
         wake_r     <= 1'b0;
      end else begin
         stat_pin_r <= stat_pin_nxt;
         wake_r     <= wake_nxt;
      end
   end

   assign cal_status_pin  = stat_pin_r;
   assign lp_wake_request = wake_r;
   assign cal_trigger     = trig_lvl;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // a stop pulse from the engine, and a resume that no set term overrides
   sequence stop_seen_s;
      cal_evt.bg_stopped;
   endsequence
   sequence resume_s;
      cal_evt.cal_resumed && !stop_set;
   endsequence

   fg_flag_set_a : assert property (
      cal_evt.foreground_complete_flag |=> fg_flag_r)
      else $error("foreground flag not set");
   stop_flag_set_a : assert property (
      stop_seen_s |=> stop_flag_r)
      else $error("halted flag not set on stop");
   stop_flag_clr_a : assert property (
      resume_s |=> !stop_flag_r)
      else $error("halted flag not cleared on resume");
   fg_bg_off_a : assert property (
      (cal_evt.foreground_complete_flag && !bg_en) |=> stop_flag_r)
      else $error("halted flag missed with background off");
   pin_low_a : assert property (
      (pin_sel == ACR_PIN_LOW) |=> !cal_status_pin)
      else $error("status pin not low");
   pin_fg_a : assert property (
      (pin_sel == ACR_PIN_FG) |=> cal_status_pin == $past(fg_flag_r))
      else $error("status pin not foreground flag");
   avg_write_a : assert property (
      wr_avg |=> cal_ctrl.offset_average_depth
                 == $past(reg_wdata[ACR_OFFSET_AVERAGE_DEPTH_LSB +: ACR_AVG_W]))
      else $error("offset depth not written");
   stat_read_a : assert property (
      (reg_re && reg_addr == ACR_OFS_STAT && !reg_we)
         |=> reg_rdata == $past(stat_word) && $stable(avg_r))
      else $error("status read wrong");
   wake_a : assert property (
      (cal_ctrl.lowpower_enable && cal_ctrl.lowpower_trigger_mode && !cal_trigger)
         |=> lp_wake_request)
      else $error("wake request missing");

endmodule // acr_cal_regs
`default_nettype wire

// >>> bench/acr_host_model.sv
// Purpose: host-side logic that drives the calibration trigger pin and watches the status pin
// Assumes: the bench commands the wanted trigger level; pin changes land on the falling edge
// Notes:   the pin idles high, so no calibration trigger is raised by accident
`timescale 1ns/1ps
`default_nettype none
module acr_host_model
   import acr_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic trig_level,
   input  wire logic cal_status_pin,
   output var  logic cal_trigger_pin,
   output var  logic status_seen
);
   // ----------------------------------------------------------------
   // trigger pin driver
   // ----------------------------------------------------------------
   // held high while idle; a low level asks a sleeping converter to wake
   always_ff @(negedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cal_trigger_pin <= 1'b1;
      end else begin
         cal_trigger_pin <= trig_level;
      end
   end

   // ----------------------------------------------------------------
   // status pin observer
   // ----------------------------------------------------------------
   // registered copy of the status pin as the host would sample it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_seen <= 1'b0;
      end else begin
         status_seen <= cal_status_pin;
      end
   end
endmodule // acr_host_model
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench of the calibration register group
// Assumes: one-cycle read and write strobes; inputs change on the falling edge
// Notes:   expected values come from the register layout, never from the design
`timescale 1ns/1ps
`default_nettype none
module testbench
   import acr_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic          clk, reset_n;          // clock and active-low reset
   logic [7:0]    reg_addr, reg_wdata;   // register port request
   logic [7:0]    reg_rdata;             // register port answer
   logic          reg_we, reg_re;        // strobes
   acr_cal_evt_t  cal_evt;               // engine events
   acr_cal_ctrl_t cal_ctrl;              // settings to the engine
   logic          cal_trigger_pin, trig_level, cal_trigger;
   logic          cal_status_pin, status_seen, lp_wake_request;
   int            fail_count, tests_run, cycles, i;
   logic [7:0]    avg_val [3] = '{8'h35, 8'h77, 8'h00}; // depth patterns
   logic          pin_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0}; // pin per source code

   acr_cal_regs u_acr_cal_regs (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .cal_evt(cal_evt), .cal_trigger_pin(cal_trigger_pin), .cal_ctrl(cal_ctrl),
      .cal_trigger(cal_trigger), .cal_status_pin(cal_status_pin),
      .lp_wake_request(lp_wake_request));
   acr_host_model u_acr_host_model (.clk(clk), .reset_n(reset_n), .trig_level(trig_level),
      .cal_status_pin(cal_status_pin), .cal_trigger_pin(cal_trigger_pin),
      .status_seen(status_seen));

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_we = 1'b0;
   endtask
   // one-cycle read strobe, answer compared once it has settled
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_re = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_re = 1'b0;
      @(negedge clk);
      chk(reg_rdata, exp);
   endtask
   // event bits (7:4) last one cycle, alarm and code (3:0) stay as levels
   task automatic pulse(input logic [7:0] e);
      @(negedge clk);
      cal_evt = acr_cal_evt_t'(e);
      @(negedge clk);
      cal_evt = acr_cal_evt_t'(e & 8'h0f);
   endtask
   task automatic waitn(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      reg_re = 1'b0;
      cal_evt = acr_cal_evt_t'(8'h00);
      trig_level = 1'b1;
      fail_count = 0;
      tests_run = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      // reset values of every register and of the engine settings except the two low-power ones
      rd(ACR_OFS_OREF, 8'h01);
      rd(ACR_OFS_AVG, 8'h61);
      rd(ACR_OFS_STAT, 8'h00);
      rd(ACR_OFS_PIN, 8'h00);
      rd(ACR_OFS_SOFT, 8'h01);
      rd(ACR_OFS_CFG0, 8'h01);
      rd(ACR_OFS_LP, 8'h88);
      chk({7'h0, cal_ctrl.background_cal_enable}, 8'h00);
      chk({7'h0, cal_ctrl.offset_reference_select}, 8'h00);
      chk({5'h0, cal_ctrl.offset_average_depth}, 8'h06);
      chk({5'h0, cal_ctrl.linearity_average_depth}, 8'h01);
      chk({7'h0, cal_trigger}, 8'h01);
      $display("test reset values done");
      // averaging depths, including both ends of the field
      for (i = 0; i < 3; i++) begin
         wr(ACR_OFS_AVG, avg_val[i]);
         chk({5'h0, cal_ctrl.offset_average_depth}, {5'h0, avg_val[i][6:4]});
         chk({5'h0, cal_ctrl.linearity_average_depth}, {5'h0, avg_val[i][2:0]});
         rd(ACR_OFS_AVG, avg_val[i]);
      end
      wr(ACR_OFS_AVG, 8'h61);
      $display("test averaging done");
      // spare reference set and cleared while background calibration is on
      wr(ACR_OFS_CFG0, 8'h03);
      chk({7'h0, cal_ctrl.background_cal_enable}, 8'h01);
      wr(ACR_OFS_OREF, 8'h05);
      chk({7'h0, cal_ctrl.offset_reference_select}, 8'h01);
      wr(ACR_OFS_OREF, 8'h01);
      chk({7'h0, cal_ctrl.offset_reference_select}, 8'h00);
      wr(ACR_OFS_CFG0, 8'h01);
      chk({7'h0, cal_ctrl.background_cal_enable}, 8'h00);
      $display("test offset reference done");
      // status flags with background off; status is read-only
      wr(ACR_OFS_STAT, 8'hff);
      rd(ACR_OFS_STAT, 8'h00);
      rd(8'h70, 8'h00);
      pulse(8'h80);
      rd(ACR_OFS_STAT, 8'h03);
      rd(ACR_OFS_STAT, 8'h03);
      pulse(8'h20);
      rd(ACR_OFS_STAT, 8'h01);
      pulse(8'h40);
      rd(ACR_OFS_STAT, 8'h03);
      pulse(8'h1d);
      rd(ACR_OFS_STAT, 8'h16);
      $display("test status flags done");
      // status pin source: foreground 0, halted 1, alarm 1, constant low
      for (i = 0; i < 4; i++) begin
         wr(ACR_OFS_PIN, {5'h0, i[1:0], 1'b0});
         waitn(3);
         chk({7'h0, cal_status_pin}, {7'h0, pin_exp[i]});
         chk({7'h0, status_seen}, {7'h0, pin_exp[i]});
      end
      // halted cleared while alarm stays high tells the two sources apart
      pulse(8'h2d);
      wr(ACR_OFS_PIN, 8'h02);
      waitn(3);
      chk({7'h0, cal_status_pin}, 8'h00);
      cal_evt = acr_cal_evt_t'(8'h00);
      $display("test status pin done");
      // trigger source: pin held low throughout the software phase
      wr(ACR_OFS_PIN, 8'h00);
      trig_level = 1'b0;
      wr(ACR_OFS_SOFT, 8'h00);
      waitn(2);
      chk({7'h0, cal_trigger}, 8'h00);
      wr(ACR_OFS_SOFT, 8'h01);
      waitn(5);
      chk({7'h0, cal_trigger}, 8'h01);
      wr(ACR_OFS_PIN, 8'h01);
      waitn(5);
      chk({7'h0, cal_trigger}, 8'h00);
      wr(ACR_OFS_LP, 8'h8b);
      waitn(3);
      chk({7'h0, lp_wake_request}, 8'h01);
      trig_level = 1'b1;
      wr(ACR_OFS_SOFT, 8'h00);
      waitn(6);
      chk({7'h0, cal_trigger}, 8'h01);
      chk({7'h0, lp_wake_request}, 8'h00);
      wr(ACR_OFS_PIN, 8'h00);
      wr(ACR_OFS_SOFT, 8'h01);
      waitn(3);
      chk({7'h0, cal_trigger}, 8'h01);
      $display("test trigger source done");
      end_sim();
   end
endmodule // testbench
`default_nettype wire
